// ==== hdl/pcg_pkg.sv ====
// Constants for the peripheral clock gate and reset cause block.
// Assumes a 100 MHz system clock and a word-addressed-by-byte Avalon-MM slave.
// What this block does
// - Bit 28 of the clock gate register switches the power interface clock, reset off.
// - Bit 21 of the clock gate register switches the two-wire clock, reset off.
// - Bit 11 of the clock gate register switches the window watchdog clock, reset off.
// - Bit 0 of the clock gate register switches the timer two clock, reset off.
// - Reads of a peripheral whose clock is gated off return zero.
// - Low-power management reset sets read-only flag bit 31.
// - Window watchdog reset sets flag bit 30.
// - Independent watchdog reset sets flag bit 29.
// - Software reset sets flag bit 28.
// - Power-up or power-down reset sets flag bit 27; it reads 1 after reset.
// - A reset through the external reset pin sets flag bit 26.
// - Writing 1 to command bit 24 clears all reset flags; writing 0 does nothing.
// - Bit 0 of the cause register enables the slow oscillator, reset off.
// - Read-only bit 1 shows the slow oscillator is stable, else 0.
// - After the enable clears, the stable flag falls after 3 slow clock cycles.
// - Reset flags clear only on power-on reset or the clear command; other bits on any system reset.
package pcg_pkg;
    localparam logic [3:0] ADDR_GATES = 4'h0;
    localparam logic [3:0] ADDR_CAUSE = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    localparam int POWER_IF_BIT = 28;
    localparam int TWO_WIRE_BIT = 21;
    localparam int WINDOW_WD_BIT = 11;
    localparam int TIMER_TWO_BIT = 0;
    localparam logic [31:0] GATES_RESET = 32'h0000_0000;

    localparam int CAUSE_LSB = 26;
    localparam int CAUSE_W = 6;
    // Flag order from bit 26 up: pin, power cycle, software, iwdg, wwdg, low power
    localparam logic [5:0] CAUSE_RESET = 6'h02;
    localparam int CLEAR_CAUSES_BIT = 24;
    localparam int OSC_STABLE_BIT = 1;
    localparam int OSC_ENABLE_BIT = 0;

    localparam int IRQ_W = 2;
    localparam int IRQ_OSC_READY = 0;
    localparam int IRQ_CAUSE_SET = 1;

    localparam longint SYS_CLK_HZ = 100_000_000;
    localparam longint SLOW_OSC_HZ = 128_000;
    localparam longint OSC_FALL_SLOW_CYCLES = 3;
    // Longest wait rounds down to whole system cycles
    localparam int OSC_FALL_CYCLES = int'((OSC_FALL_SLOW_CYCLES * SYS_CLK_HZ) / SLOW_OSC_HZ);
    localparam int FALL_CNT_W = 12;

    typedef enum logic [1:0] {
        PCG_OSC_OFF = 2'b00,
        PCG_OSC_WAIT = 2'b01,
        PCG_OSC_READY = 2'b10,
        PCG_OSC_DRAIN = 2'b11
    } pcg_osc_state_t;
endpackage

// ==== hdl/pcg_clock_gate_reset_cause.sv ====
// Peripheral clock gates, reset cause flags and slow oscillator control.
// Assumes por is a synchronous power-on reset that also implies rst, event inputs are
// one-cycle pulses on clk, and the pin and oscillator status arrive asynchronously.
`timescale 1ns/1ps
module pcg_clock_gate_reset_cause
    import pcg_pkg::*;
#(
    parameter int FALL_CYCLES = OSC_FALL_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic low_power_reset_evt,
    input wire logic window_watchdog_reset_evt,
    input wire logic independent_watchdog_reset_evt,
    input wire logic software_reset_evt,
    input wire logic external_reset_pin_n,
    input wire logic slow_osc_stable_in,
    output logic slow_osc_enable,
    output logic power_if_clock_on,
    output logic two_wire_clock_on,
    output logic window_watchdog_clock_on,
    output logic timer_two_clock_on,
    input wire logic [31:0] power_if_rdata,
    input wire logic [31:0] two_wire_rdata,
    input wire logic [31:0] window_watchdog_rdata,
    input wire logic [31:0] timer_two_rdata,
    output logic [31:0] power_if_rdata_gated,
    output logic [31:0] two_wire_rdata_gated,
    output logic [31:0] window_watchdog_rdata_gated,
    output logic [31:0] timer_two_rdata_gated,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] gate_word(input logic on, input logic [31:0] data);
        return on ? data : 32'h0000_0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic pin_meta;
    logic pin_sync_n;
    logic osc_meta;
    logic osc_sync;

    always_ff @(posedge clk)
    begin
        pin_meta <= external_reset_pin_n;
        pin_sync_n <= pin_meta;
        osc_meta <= slow_osc_stable_in;
        osc_sync <= osc_meta;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then answer

    logic bus_req;
    logic bus_commit;
    logic wr_commit;
    logic [31:0] wmerged;
    logic [31:0] gates_word;
    logic [31:0] cause_word;
    logic [31:0] next_readdata;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [CAUSE_W-1:0] causes;
    logic osc_ready;

    assign bus_req = avs_read | avs_write;
    assign bus_commit = bus_req & ~avs_waitrequest;
    assign wr_commit = avs_write & ~avs_waitrequest;

    always_comb
    begin
        gates_word = 32'h0000_0000;
        gates_word[POWER_IF_BIT] = power_if_clock_on;
        gates_word[TWO_WIRE_BIT] = two_wire_clock_on;
        gates_word[WINDOW_WD_BIT] = window_watchdog_clock_on;
        gates_word[TIMER_TWO_BIT] = timer_two_clock_on;
        cause_word = 32'h0000_0000;
        cause_word[CAUSE_LSB +: CAUSE_W] = causes;
        cause_word[OSC_STABLE_BIT] = osc_ready;
        cause_word[OSC_ENABLE_BIT] = slow_osc_enable;
    end

    always_comb
    begin
        if (avs_address == ADDR_GATES)
        begin
            next_readdata = gates_word;
            wmerged = merge_bytes(gates_word, avs_writedata, avs_byteenable);
        end
        else if (avs_address == ADDR_CAUSE)
        begin
            next_readdata = cause_word;
            wmerged = merge_bytes(32'h0000_0000, avs_writedata, avs_byteenable);
        end
        else if (avs_address == ADDR_IRQ_STATUS)
        begin
            next_readdata = {{(32-IRQ_W){1'b0}}, irq_status};
            wmerged = merge_bytes(32'h0000_0000, avs_writedata, avs_byteenable);
        end
        else if (avs_address == ADDR_IRQ_MASK)
        begin
            next_readdata = {{(32-IRQ_W){1'b0}}, irq_mask};
            wmerged = merge_bytes({{(32-IRQ_W){1'b0}}, irq_mask}, avs_writedata,
                                  avs_byteenable);
        end
        else
        begin
            // Unmapped words read zero and ignore writes
            next_readdata = 32'h0000_0000;
            wmerged = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read && avs_waitrequest)
            begin
                avs_readdata <= next_readdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Clock gates and gated peripheral read data

    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            power_if_clock_on <= GATES_RESET[POWER_IF_BIT];
            two_wire_clock_on <= GATES_RESET[TWO_WIRE_BIT];
            window_watchdog_clock_on <= GATES_RESET[WINDOW_WD_BIT];
            timer_two_clock_on <= GATES_RESET[TIMER_TWO_BIT];
        end
        else if (wr_commit && avs_address == ADDR_GATES)
        begin
            power_if_clock_on <= wmerged[POWER_IF_BIT];
            two_wire_clock_on <= wmerged[TWO_WIRE_BIT];
            window_watchdog_clock_on <= wmerged[WINDOW_WD_BIT];
            timer_two_clock_on <= wmerged[TIMER_TWO_BIT];
        end
    end

    // Registered so that the read path stays clean; costs one cycle of latency
    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            power_if_rdata_gated <= 32'h0000_0000;
            two_wire_rdata_gated <= 32'h0000_0000;
            window_watchdog_rdata_gated <= 32'h0000_0000;
            timer_two_rdata_gated <= 32'h0000_0000;
        end
        else
        begin
            power_if_rdata_gated <= gate_word(power_if_clock_on, power_if_rdata);
            two_wire_rdata_gated <= gate_word(two_wire_clock_on, two_wire_rdata);
            window_watchdog_rdata_gated <=
                gate_word(window_watchdog_clock_on, window_watchdog_rdata);
            timer_two_rdata_gated <= gate_word(timer_two_clock_on, timer_two_rdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Reset cause flags: survive rst, cleared only by por or the clear command

    logic [CAUSE_W-1:0] cause_set;
    logic clear_cmd;

    assign cause_set = {low_power_reset_evt, window_watchdog_reset_evt,
                        independent_watchdog_reset_evt, software_reset_evt,
                        1'b0, ~pin_sync_n};
    assign clear_cmd = wr_commit && avs_address == ADDR_CAUSE && wmerged[CLEAR_CAUSES_BIT];

    always_ff @(posedge clk)
    begin
        if (por)
        begin
            causes <= CAUSE_RESET;
        end
        else
        begin
            // A new cause wins over a clear in the same cycle
            causes <= (clear_cmd ? {CAUSE_W{1'b0}} : causes) | cause_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Slow oscillator enable and stable flag

    pcg_osc_state_t osc_state;
    logic [FALL_CNT_W-1:0] fall_cnt;

    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            slow_osc_enable <= 1'b0;
        end
        else if (wr_commit && avs_address == ADDR_CAUSE && avs_byteenable[0])
        begin
            slow_osc_enable <= avs_writedata[OSC_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            osc_state <= PCG_OSC_OFF;
            osc_ready <= 1'b0;
            fall_cnt <= '0;
        end
        else
        begin
            case (osc_state)
                PCG_OSC_OFF:
                begin
                    osc_ready <= 1'b0;
                    if (slow_osc_enable)
                    begin
                        osc_state <= PCG_OSC_WAIT;
                    end
                end
                PCG_OSC_WAIT:
                begin
                    if (!slow_osc_enable)
                    begin
                        osc_state <= PCG_OSC_OFF;
                    end
                    else if (osc_sync)
                    begin
                        osc_state <= PCG_OSC_READY;
                        osc_ready <= 1'b1;
                    end
                end
                PCG_OSC_READY:
                begin
                    if (!slow_osc_enable)
                    begin
                        osc_state <= PCG_OSC_DRAIN;
                        fall_cnt <= FALL_CNT_W'(FALL_CYCLES - 1);
                    end
                    else if (!osc_sync)
                    begin
                        osc_state <= PCG_OSC_WAIT;
                        osc_ready <= 1'b0;
                    end
                end
                PCG_OSC_DRAIN:
                begin
                    if (fall_cnt <= FALL_CNT_W'(1))
                    begin
                        osc_state <= PCG_OSC_OFF;
                        osc_ready <= 1'b0;
                    end
                    else
                    begin
                        fall_cnt <= fall_cnt - FALL_CNT_W'(1);
                    end
                end
                default:
                begin
                    osc_state <= PCG_OSC_OFF;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic [IRQ_W-1:0] irq_event;
    logic ready_d;
    logic irq_clear;

    assign irq_event = {|(cause_set & ~causes), osc_ready & ~ready_d};
    assign irq_clear = wr_commit && avs_address == ADDR_IRQ_STATUS;

    always_ff @(posedge clk)
    begin
        if (rst || por)
        begin
            ready_d <= 1'b0;
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            ready_d <= osc_ready;
            irq_status <= (irq_status & ~(irq_clear ? wmerged[IRQ_W-1:0] : '0)) | irq_event;
            if (wr_commit && avs_address == ADDR_IRQ_MASK)
            begin
                irq_mask <= wmerged[IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence gate_write_s;
        avs_write && !avs_waitrequest && avs_address == ADDR_GATES && avs_byteenable == 4'hf;
    endsequence

    sequence cause_clear_s;
        avs_write && !avs_waitrequest && avs_address == ADDR_CAUSE &&
        avs_byteenable[3] && avs_writedata[CLEAR_CAUSES_BIT];
    endsequence

    chk_power_gate_write: assert property (@(posedge clk) disable iff (rst || por)
        gate_write_s |=> power_if_clock_on == $past(avs_writedata[POWER_IF_BIT]))
        else $error("power interface gate did not follow write");

    chk_two_wire_gate: assert property (@(posedge clk) disable iff (rst || por)
        gate_write_s |=> two_wire_clock_on == $past(avs_writedata[TWO_WIRE_BIT]))
        else $error("two-wire gate did not follow write");

    chk_wwdg_gate_write: assert property (@(posedge clk) disable iff (rst || por)
        gate_write_s |=> window_watchdog_clock_on == $past(avs_writedata[WINDOW_WD_BIT]))
        else $error("window watchdog gate did not follow write");

    chk_timer_gate_write: assert property (@(posedge clk) disable iff (rst || por)
        gate_write_s |=> timer_two_clock_on == $past(avs_writedata[TIMER_TWO_BIT]))
        else $error("timer two gate did not follow write");

    chk_gated_read_zero: assert property (@(posedge clk) disable iff (rst || por)
        !two_wire_clock_on |=> two_wire_rdata_gated == 32'h0000_0000)
        else $error("gated peripheral returned data");

    chk_cause_sticky_set: assert property (@(posedge clk) disable iff (por)
        low_power_reset_evt |=> causes[5] ##1 (causes[5] || $past(clear_cmd)))
        else $error("low-power reset flag not held");

    chk_wwdg_cause_set: assert property (@(posedge clk) disable iff (por)
        window_watchdog_reset_evt |=> causes[4])
        else $error("window watchdog reset flag not set");

    chk_iwdg_cause_set: assert property (@(posedge clk) disable iff (por)
        independent_watchdog_reset_evt |=> causes[3])
        else $error("independent watchdog reset flag not set");

    chk_soft_cause_set: assert property (@(posedge clk) disable iff (por)
        software_reset_evt |=> causes[2])
        else $error("software reset flag not set");

    chk_por_cause_value: assert property (@(posedge clk)
        por |=> causes == CAUSE_RESET)
        else $error("power cycle flag not set after power-on reset");

    chk_pin_cause_set: assert property (@(posedge clk) disable iff (por)
        !pin_sync_n |=> causes[0])
        else $error("pin reset flag not set");

    chk_clear_causes: assert property (@(posedge clk) disable iff (rst || por)
        cause_clear_s ##0 (cause_set == '0) |=> causes == '0)
        else $error("clear command left a reset flag set");

    chk_osc_enable_write: assert property (@(posedge clk) disable iff (rst || por)
        avs_write && !avs_waitrequest && avs_address == ADDR_CAUSE && avs_byteenable[0]
        |=> slow_osc_enable == $past(avs_writedata[OSC_ENABLE_BIT]))
        else $error("oscillator enable did not follow write");

    chk_ready_needs_on: assert property (@(posedge clk) disable iff (rst || por)
        $rose(osc_ready) |-> $past(slow_osc_enable) && $past(osc_sync))
        else $error("stable flag rose without enable");

    chk_ready_fall_time: assert property (@(posedge clk) disable iff (rst || por)
        osc_state == PCG_OSC_READY && !slow_osc_enable |=> osc_ready [*2])
        else $error("stable flag fell too early");

    chk_flags_keep_rst: assert property (@(posedge clk) disable iff (por)
        rst && cause_set == '0 && !clear_cmd |=> causes == $past(causes))
        else $error("system reset disturbed reset flags");

endmodule

// ==== tb/pcg_clock_gate_reset_cause_test.sv ====
// Self-checking bench for the peripheral clock gate and reset cause block.
// Assumes the Avalon slave answers after one wait cycle and a shortened fall delay.
`timescale 1ns/1ps
module pcg_clock_gate_reset_cause_test
    import pcg_pkg::*;
;
    localparam int FALL = 8;
    logic clk, rst, por, avs_read, avs_write, avs_waitrequest, pin_n, osc_in, osc_en, irq;
    logic [3:0] avs_address, avs_byteenable, evt, gon;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [31:0] prd [4];
    logic [31:0] grd [4];
    int n_mismatch = 0;
    int tests_run = 0;

    pcg_clock_gate_reset_cause #(.FALL_CYCLES(FALL)) i_dut (.clk(clk), .rst(rst), .por(por),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .low_power_reset_evt(evt[3]), .window_watchdog_reset_evt(evt[2]),
        .independent_watchdog_reset_evt(evt[1]), .software_reset_evt(evt[0]),
        .external_reset_pin_n(pin_n), .slow_osc_stable_in(osc_in), .slow_osc_enable(osc_en),
        .power_if_clock_on(gon[3]), .two_wire_clock_on(gon[2]),
        .window_watchdog_clock_on(gon[1]), .timer_two_clock_on(gon[0]),
        .power_if_rdata(prd[3]), .two_wire_rdata(prd[2]), .window_watchdog_rdata(prd[1]),
        .timer_two_rdata(prd[0]), .power_if_rdata_gated(grd[3]),
        .two_wire_rdata_gated(grd[2]), .window_watchdog_rdata_gated(grd[1]),
        .timer_two_rdata_gated(grd[0]), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Entered just after a rising edge; leaves one idle edge so strobes never toggle twice
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 50)
        begin
            n_mismatch++;
            $display("MISMATCH bus_answer expected 1 seen 0");
            results();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        check(what, rd & m, exp);
    endtask

    task automatic pulse(input int k);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt[k] <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_irq(input logic exp);
        int i;
        for (i = 0; i < 10; i++)
        begin
            @(posedge clk);
            if (irq === exp)
                break;
        end
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk("gates", ADDR_GATES, 32'hffff_ffff, 32'h0000_0000);
        rdchk("cause", ADDR_CAUSE, 32'hffff_ffff, 32'h0800_0000);
        check("gate_outs", {28'h0, gon}, 32'h0000_0000);
        check("osc_enable", {31'h0, osc_en}, 32'h0000_0000);
        // Nothing lives between word offsets, so it must read empty
        rdchk("unmapped", 4'h2, 32'hffff_ffff, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_gates();
        int bits [4] = '{0, 11, 21, 28};
        for (int g = 0; g < 4; g++)
        begin
            wr(ADDR_GATES, 32'h1 << bits[g]);
            repeat (3) @(posedge clk);
            check("gate_outs", {28'h0, gon}, 32'h1 << g);
            rdchk("gates", ADDR_GATES, 32'hffff_ffff, 32'h1 << bits[g]);
            for (int k = 0; k < 4; k++)
                check("gated_rdata", grd[k], (k == g) ? prd[k] : 32'h0);
        end
        bus(1'b1, ADDR_GATES, 32'hffff_ffff, 4'h1);
        // Only lane 0 is written, so the power interface gate from the loop stays on
        rdchk("gates_lane0", ADDR_GATES, 32'hffff_ffff, 32'h1000_0001);
        wr(ADDR_GATES, 32'hffff_ffff);
        rdchk("gates_all", ADDR_GATES, 32'hffff_ffff, 32'h1020_0801);
        $display("test gates done");
    endtask

    task automatic t_flags();
        logic [31:0] exp = 32'h0;
        wr(ADDR_CAUSE, 32'h0100_0000);
        rdchk("flags_cleared", ADDR_CAUSE, 32'hff00_0000, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            pulse(k);
            exp[28 + k] = 1'b1;
            rdchk("flag_set", ADDR_CAUSE, 32'hfc00_0000, exp);
        end
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        exp[26] = 1'b1;
        rdchk("pin_flag", ADDR_CAUSE, 32'hfc00_0000, exp);
        wr(ADDR_CAUSE, 32'hfe00_0000);
        rdchk("flags_ro", ADDR_CAUSE, 32'hff00_0000, exp);
        wr(ADDR_CAUSE, 32'h0100_0000);
        rdchk("flags_clear", ADDR_CAUSE, 32'hff00_0000, 32'h0);
        wr(ADDR_GATES, 32'hffff_ffff);
        wr(ADDR_CAUSE, 32'h0000_0001);
        pulse(0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("gates_sysrst", {27'h0, osc_en, gon}, 32'h0);
        rdchk("flags_keep", ADDR_CAUSE, 32'hff00_0003, 32'h1000_0000);
        wr(ADDR_CAUSE, 32'h0100_0000);
        $display("test flags done");
    endtask

    task automatic t_irq();
        wr(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h3);
        pulse(3);
        wait_irq(1'b1);
        rdchk("irq_status", ADDR_IRQ_STATUS, 32'h2, 32'h2);
        wr(ADDR_IRQ_STATUS, 32'h2);
        wait_irq(1'b0);
        wr(ADDR_IRQ_MASK, 32'h0);
        pulse(2);
        repeat (4) @(posedge clk);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rdchk("irq_sticky", ADDR_IRQ_STATUS, 32'h2, 32'h2);
        wr(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_CAUSE, 32'h0100_0000);
        $display("test irq done");
    endtask

    task automatic t_osc();
        wr(ADDR_CAUSE, 32'h0000_0001);
        check("osc_enable", {31'h0, osc_en}, 32'h1);
        repeat (6) @(posedge clk);
        rdchk("osc_unstable", ADDR_CAUSE, 32'h3, 32'h1);
        osc_in <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk("osc_stable", ADDR_CAUSE, 32'h3, 32'h3);
        bus(1'b1, ADDR_CAUSE, 32'h0, 4'h1);
        check("osc_disable", {31'h0, osc_en}, 32'h0);
        // Oscillator still reports stable, so only the fall delay can drop the flag
        rdchk("osc_hold", ADDR_CAUSE, 32'h3, 32'h2);
        repeat (FALL + 4) @(posedge clk);
        rdchk("osc_fallen", ADDR_CAUSE, 32'h3, 32'h0);
        $display("test osc done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        por = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        evt = 4'h0;
        pin_n = 1'b1;
        osc_in = 1'b0;
        prd[0] = 32'h1357_9bdf;
        prd[1] = 32'h2468_ace0;
        prd[2] = 32'h0f0f_a5a5;
        prd[3] = 32'hdead_0001;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        t_reset();
        t_gates();
        t_flags();
        t_irq();
        t_osc();
        results();
    end
endmodule
